/* nv_flash_ctrl.sv */
// AHB-Lite controller for the self-writable flash data memory
`default_nettype none
`include "nv_cfg.svh"

// Summary of operation
// [R1] Row-erase select sets by any write; unlock and start only by set alias
// [R2] Row erase picks the row from address bits 5 to 3
// [R3] Core is stalled for the whole erase or write cycle
// [R4] One byte per write: latch data, then program it at once
// [R5] Software loads address, data, sets unlock, sets start
// [R6] Unlock clears unless start is set by the very next transfer
// [R7] Transfer after read or start runs correctly without a spacer
// [R8] Data register holds eight bits of write and read data
// [R9] Address register holds six bits; bits 7 and 6 read zero
// [R10] Erase select makes the next cycle a row erase; cleared on completion
// [R11] Abort flag set when reset cuts a write; clear after a good one
// [R12] Unlock bit permits erase or write cycles; zero inhibits them
// [R13] Start bit launches a cycle and reads zero once it completes
// [R14] Read bit starts a read of the addressed location
// [R15] Code protection never blocks read, erase or write
// [R16] Software erases a cell before writing new data to it
// [R17] Read data lands at once and holds until next read or write
// [R18] Erase select clears unless unlock is set by the very next transfer
// [R19] Cells are 12 bits; writes drive the upper four bits as ones, so those bits keep their value
// [R20] Array holds sixty-four byte locations
// [R21] Stall from start to completion; start clears as stall releases
// [R22] Reset during a cycle aborts it, sets abort flag, clears the rest
module nv_flash_ctrl #(
   parameter int ADDR_W = 6,
   parameter int PROG_CYCLES = `NV_PROG_CYCLES
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic por_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic stall_req
);
   initial
   begin
      if (ADDR_W != `NV_ROW_HI + 1)
         $error("nv_flash_ctrl: address width must match row field");
      if (PROG_CYCLES < 1 || PROG_CYCLES > 65535)
         $error("nv_flash_ctrl: PROG_CYCLES out of range");
   end

   nv_pkg::nv_state_t state;
   logic [7:0] a_ofs;
   logic a_wr;
   logic [15:0] cnt;
   logic [7:0] nv_data_reg;
   logic [ADDR_W-1:0] nv_addr_reg;
   logic free_bit;
   logic program_unlock;
   logic start_bit;
   logic read_bit;
   logic abort_flag;
   logic free_fresh;
   logic unlock_fresh;
   logic cycle_live;
   logic [11:0] mem_rdata;

   // Decode of the transfer in its data phase
   logic in_acc;
   logic set_ok;
   logic ctrl_wr;
   logic go_prog;
   logic go_read;
   logic prog_done;

   function automatic logic one_bit_set(input logic [7:0] v);
      return v != 8'h00 && (v & (v - 8'h01)) == 8'h00;
   endfunction

   function automatic logic [31:0] reg_view(input logic [7:0] ofs);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (ofs)
         `NV_OFS_DATA: v[7:0] = nv_data_reg;
         `NV_OFS_ADDR: v[ADDR_W-1:0] = nv_addr_reg; // R9
         `NV_OFS_CTRL, `NV_OFS_SET:
            v[7:0] = {3'b000, free_bit, abort_flag, program_unlock,
                      start_bit, read_bit};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   assign in_acc = state == nv_pkg::st_access;
   // Set alias models the single-bit-set instruction
   assign set_ok = in_acc && a_wr && a_ofs == `NV_OFS_SET
                   && one_bit_set(hwdata[7:0]); // R1
   assign ctrl_wr = in_acc && a_wr && a_ofs == `NV_OFS_CTRL;
   // Unlock must be set and fresh from the previous transfer
   assign go_prog = set_ok && hwdata[`NV_B_START] && program_unlock
                    && unlock_fresh; // R12
   assign go_read = set_ok && hwdata[`NV_B_READ]; // R14
   assign prog_done = state == nv_pkg::st_prog && cnt == 16'h0000;

   // Bus state, wait states and the core stall
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= nv_pkg::st_idle;
         a_ofs <= 8'h00;
         a_wr <= 1'b0;
         cnt <= 16'h0000;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
         stall_req <= 1'b0;
      end
      else
      begin
         hresp <= 1'b0;
         case (state)
            nv_pkg::st_idle:
            begin
               if (hsel && htrans[1] && hready)
               begin
                  a_ofs <= haddr[7:0];
                  a_wr <= hwrite;
                  hreadyout <= 1'b0;
                  state <= nv_pkg::st_access;
               end
            end
            nv_pkg::st_access:
            begin
               if (go_prog)
               begin
                  // Bus held low: the core waits out the cycle
                  cnt <= 16'(PROG_CYCLES - 1);
                  stall_req <= 1'b1; // R3 R21
                  state <= nv_pkg::st_prog;
               end
               else if (go_read)
                  state <= nv_pkg::st_fetch;
               else
               begin
                  hrdata <= a_wr ? 32'h0000_0000 : reg_view(a_ofs);
                  hreadyout <= 1'b1;
                  state <= nv_pkg::st_idle;
               end
            end
            nv_pkg::st_fetch:
            begin
               // Next transfer is taken only after data landed
               hrdata <= 32'h0000_0000;
               hreadyout <= 1'b1; // R7
               state <= nv_pkg::st_idle;
            end
            nv_pkg::st_prog:
            begin
               if (cnt == 16'h0000)
               begin
                  hrdata <= 32'h0000_0000;
                  stall_req <= 1'b0; // R21
                  hreadyout <= 1'b1; // R7
                  state <= nv_pkg::st_idle;
               end
               else
                  cnt <= cnt - 16'h0001;
            end
            default:
            begin
               hreadyout <= 1'b1;
               stall_req <= 1'b0;
               state <= nv_pkg::st_idle;
            end
         endcase
      end
   end

   // Control bits with their hardware expiry
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // A cut cycle leaves these cleared
         free_bit <= 1'b0; // R22
         program_unlock <= 1'b0;
         start_bit <= 1'b0;
         read_bit <= 1'b0;
         free_fresh <= 1'b0;
         unlock_fresh <= 1'b0;
      end
      else if (in_acc)
      begin
         free_fresh <= 1'b0;
         unlock_fresh <= 1'b0;
         start_bit <= go_prog; // R13
         read_bit <= go_read;
         if ((set_ok || ctrl_wr) && hwdata[`NV_B_FREE])
         begin
            free_bit <= 1'b1; // R1
            free_fresh <= 1'b1;
         end
         else if (free_fresh && !(set_ok && hwdata[`NV_B_UNLOCK]))
            free_bit <= 1'b0; // R18
         else if (ctrl_wr)
            free_bit <= 1'b0;
         if (set_ok && hwdata[`NV_B_UNLOCK])
         begin
            program_unlock <= 1'b1; // R1
            unlock_fresh <= 1'b1;
         end
         else if (unlock_fresh && !go_prog)
            program_unlock <= 1'b0; // R6
         else if (ctrl_wr)
            program_unlock <= program_unlock & hwdata[`NV_B_UNLOCK];
      end
      else if (state == nv_pkg::st_fetch)
         read_bit <= 1'b0;
      else if (prog_done)
      begin
         start_bit <= 1'b0; // R13 R21
         free_bit <= 1'b0; // R10
         program_unlock <= 1'b0;
      end
   end

   // Data and address registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         nv_data_reg <= `NV_DATA_RESET;
         nv_addr_reg <= `NV_ADDR_RESET;
      end
      else
      begin
         if (in_acc && a_wr && a_ofs == `NV_OFS_DATA)
            nv_data_reg <= hwdata[7:0]; // R8
         else if (state == nv_pkg::st_fetch)
            nv_data_reg <= mem_rdata[7:0]; // R17
         if (in_acc && a_wr && a_ofs == `NV_OFS_ADDR)
            nv_addr_reg <= hwdata[ADDR_W-1:0]; // R9
      end
   end

   // Abort flag lives through device reset so software can see the cut
   always_ff @(posedge hclk or negedge por_n)
   begin
      if (!por_n)
      begin
         abort_flag <= 1'b0;
         cycle_live <= 1'b0;
      end
      else if (!hresetn)
      begin
         if (cycle_live)
            abort_flag <= 1'b1; // R11 R22
         cycle_live <= 1'b0;
      end
      else if (go_prog)
         cycle_live <= 1'b1;
      else if (prog_done)
      begin
         cycle_live <= 1'b0;
         abort_flag <= 1'b0; // R11
      end
      else if (set_ok && hwdata[`NV_B_ABORT])
         abort_flag <= 1'b1;
      else if (ctrl_wr)
         abort_flag <= hwdata[`NV_B_ABORT];
   end

   // No protection input exists: access is never gated here (R15)
   nv_array_mem #(
      .AW(ADDR_W),
      .CW(12),
      .ROW_W(`NV_ROW_HI - `NV_ROW_LO + 1)
   ) u_array (
      .clk(hclk),
      .rd_en(in_acc && go_read),
      .addr(nv_addr_reg),
      .rd_data(mem_rdata),
      .wr_en(prog_done && !free_bit), // R4 R20
      .wr_data({`NV_UPPER_ONES, nv_data_reg}), // R19
      .erase_en(prog_done && free_bit), // R10
      .erase_row(nv_addr_reg[`NV_ROW_HI:`NV_ROW_LO]) // R2
   );

   a_stall_holds_bus: assert property ( // R3
      @(posedge hclk) disable iff (!hresetn)
      stall_req |-> !hreadyout)
      else $error("bus released while core stalled");

   a_unlock_expiry: assert property ( // R6
      @(posedge hclk) disable iff (!hresetn)
      in_acc && unlock_fresh && !go_prog
      && !(set_ok && hwdata[`NV_B_UNLOCK]) |=> !program_unlock)
      else $error("unlock survived a missed start");

   a_free_expiry: assert property ( // R18
      @(posedge hclk) disable iff (!hresetn)
      in_acc && free_fresh && !(set_ok && hwdata[`NV_B_UNLOCK])
      && !((set_ok || ctrl_wr) && hwdata[`NV_B_FREE]) |=> !free_bit)
      else $error("erase select survived a missed unlock");

   a_start_locked: assert property ( // R12
      @(posedge hclk) disable iff (!hresetn)
      set_ok && hwdata[`NV_B_START] && !program_unlock
      |=> !stall_req && !start_bit)
      else $error("cycle started without unlock");

   a_release_clean: assert property ( // R21
      @(posedge hclk) disable iff (!hresetn)
      $fell(stall_req) |-> !start_bit && !free_bit && hreadyout)
      else $error("start or erase select left after cycle");

   a_good_cycle: assert property ( // R11
      @(posedge hclk) disable iff (!hresetn)
      $fell(stall_req) |-> !abort_flag && !cycle_live)
      else $error("abort flag set after a good cycle");

   a_read_lands: assert property ( // R17
      @(posedge hclk) disable iff (!hresetn)
      state == nv_pkg::st_fetch
      |=> nv_data_reg == $past(mem_rdata[7:0]) && hreadyout && !read_bit)
      else $error("read data not loaded");

   a_addr_upper_zero: assert property ( // R9
      @(posedge hclk) disable iff (!hresetn)
      in_acc && !a_wr && a_ofs == `NV_OFS_ADDR
      |=> hrdata[31:ADDR_W] == '0 && hreadyout)
      else $error("address upper bits not zero");

   a_stall_span: assert property ( // R3
      @(posedge hclk) disable iff (!hresetn)
      $rose(stall_req) |-> start_bit && cnt == 16'(PROG_CYCLES - 1))
      else $error("cycle counter not loaded at start");
endmodule
`default_nettype wire

/* nv_cfg.svh */
// Offsets, field positions, reset values and timing of the flash data control
`ifndef NV_CFG_SVH
`define NV_CFG_SVH

`define NV_OFS_DATA 8'h00
`define NV_OFS_ADDR 8'h04
`define NV_OFS_CTRL 8'h08
`define NV_OFS_SET 8'h0C

`define NV_B_FREE 4
`define NV_B_ABORT 3
`define NV_B_UNLOCK 2
`define NV_B_START 1
`define NV_B_READ 0

`define NV_ROW_HI 5
`define NV_ROW_LO 3

`define NV_CTRL_RESET 8'h00
`define NV_DATA_RESET 8'h00
`define NV_ADDR_RESET 6'h00
`define NV_UPPER_ONES 4'hF
`define NV_CELL_ERASED 12'hFFF

`define NV_CLK_PERIOD_NS 25
`define NV_PROG_TIME_NS 2000
`define NV_PROG_CYCLES \
   ((`NV_PROG_TIME_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)

`endif

/* nv_pkg.sv */
// Types shared by the flash data controller
`default_nettype none
package nv_pkg;
   typedef enum logic [3:0]
   {
      st_idle = 4'b0001,
      st_access = 4'b0010,
      st_fetch = 4'b0100,
      st_prog = 4'b1000
   } nv_state_t;
endpackage
`default_nettype wire

/* nv_array_mem.sv */
// Flash data array: 12-bit cells, registered read, byte write, row erase
`default_nettype none
module nv_array_mem #(
   parameter int AW = 6,
   parameter int CW = 12,
   parameter int ROW_W = 3
)(
   input wire logic clk,
   input wire logic rd_en,
   input wire logic [AW-1:0] addr,
   output logic [CW-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [CW-1:0] wr_data,
   input wire logic erase_en,
   input wire logic [ROW_W-1:0] erase_row
);
   localparam int ROW_CELLS = 1 << (AW - ROW_W);

   initial
   begin
      if (AW <= ROW_W || CW < 8)
         $error("nv_array_mem: unsupported geometry");
   end

   logic [CW-1:0] cells [0:(1<<AW)-1];

   // Programming can only clear bits, so a write on a dirty cell mixes data
   always_ff @(posedge clk)
   begin
      if (erase_en)
      begin
         for (int i = 0; i < ROW_CELLS; i++)
            cells[{erase_row, (AW-ROW_W)'(i)}] <= {CW{1'b1}};
      end
      else if (wr_en)
         cells[addr] <= cells[addr] & wr_data;
   end

   always_ff @(posedge clk)
   begin
      if (rd_en)
         rd_data <= cells[addr];
   end
endmodule
`default_nettype wire

/* nv_core_model.sv */
// Bus master model of the core issuing bit-set and move instructions
`default_nettype none
`include "nv_cfg.svh"
module nv_core_model (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic stall_req,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   int stall_cnt = 0;
   // Waits that ran out of patience; the bench counts them as mismatches
   int timeouts = 0;

   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'hA5A5_A5A5;
   end

   always @(posedge hclk)
      if (stall_req === 1'b1)
         stall_cnt <= stall_cnt + 1;

   // Entered just past a rising edge, so transfers run back to back
   task automatic xfer(input logic wr, input logic [7:0] ofs,
      input logic [31:0] wd, output logic [31:0] rd, output int stalls);
      int n;
      int s0;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h00_0000, ofs};
      htrans <= 2'h2;
      hwrite <= wr;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 2000);
      if (hready !== 1'b1)
         timeouts++;
      s0 = stall_cnt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 2000);
      if (hready !== 1'b1)
         timeouts++;
      rd = hrdata;
      stalls = stall_cnt - s0;
      // Released data lines must not keep a value the slave could reuse
      hwdata <= ~wd;
   endtask

   task automatic set_bit(input int b, output int stalls);
      logic [31:0] r;
      xfer(1'b1, `NV_OFS_SET, 32'h0000_0001 << b, r, stalls);
   endtask

   task automatic program_byte(input logic [7:0] a, input logic [7:0] d,
      output int stalls);
      logic [31:0] r;
      xfer(1'b1, `NV_OFS_ADDR, {24'h00_0000, a}, r, stalls);
      xfer(1'b1, `NV_OFS_DATA, {24'h00_0000, d}, r, stalls);
      set_bit(`NV_B_UNLOCK, stalls);
      set_bit(`NV_B_START, stalls);
   endtask

   task automatic erase_row(input logic [7:0] a, output int stalls);
      logic [31:0] r;
      xfer(1'b1, `NV_OFS_ADDR, {24'h00_0000, a}, r, stalls);
      xfer(1'b1, `NV_OFS_CTRL, 32'h0000_0010, r, stalls);
      set_bit(`NV_B_UNLOCK, stalls);
      set_bit(`NV_B_START, stalls);
   endtask
endmodule
`default_nettype wire

/* test_self_write_flash_data_ctrl.sv */
// Self-checking bench for the flash data controller
`default_nettype none
`include "nv_cfg.svh"
module test_self_write_flash_data_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 4;
   localparam logic [7:0] DAT = `NV_OFS_DATA;
   localparam logic [7:0] ADR = `NV_OFS_ADDR;
   localparam logic [7:0] CTL = `NV_OFS_CTRL;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic por_n = 1'b0;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic stall_req;
   int num_errors = 0;
   int num_checks = 0;
   int s;
   logic [31:0] v;

   always #12.5 hclk = ~hclk;

   nv_flash_ctrl #(.ADDR_W(6), .PROG_CYCLES(P)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .stall_req(stall_req));

   nv_core_model u_core (
      .hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .stall_req(stall_req), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hwdata(hwdata));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      u_core.xfer(1'b1, ofs, d, v, s);
   endtask

   task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
      u_core.xfer(1'b0, ofs, 32'h0000_0000, v, s);
      check(v, exp);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask

   task automatic rd_cell(input logic [7:0] a, input logic [31:0] exp);
      wr(ADR, {24'h00_0000, a});
      u_core.set_bit(`NV_B_READ, s);
      rd(DAT, exp);
   endtask

   task automatic t_reset_values();
      rd(DAT, 32'h0000_0000);
      rd(ADR, 32'h0000_0000);
      rd(CTL, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
   endtask

   task automatic t_regs();
      wr(ADR, 32'hFFFF_FFFF);
      rd(ADR, 32'h0000_003F);
      wr(DAT, 32'h0000_00A5);
      rd(DAT, 32'h0000_00A5);
   endtask

   task automatic t_erase_write();
      u_core.erase_row(8'h20, s);
      check(32'(s), 32'(P));
      u_core.program_byte(8'h20, 8'h11, s);
      check(32'(s), 32'(P));
      // Erase before writing: cell contents are unknown out of reset
      u_core.erase_row(8'h3F, s);
      rd(CTL, 32'h0000_0000);
      rd_cell(8'h20, 32'h0000_0011);
      rd_cell(8'h38, 32'h0000_00FF);
      u_core.program_byte(8'h3F, 8'h5A, s);
      check(32'(s), 32'(P));
      rd(CTL, 32'h0000_0000);
      rd_cell(8'h3F, 32'h0000_005A);
      rd(DAT, 32'h0000_005A);
   endtask

   task automatic t_lapses();
      rd_cell(8'h20, 32'h0000_0011);
      u_core.set_bit(`NV_B_UNLOCK, s);
      rd(DAT, 32'h0000_0011);
      u_core.set_bit(`NV_B_START, s);
      check(32'(s), 32'h0000_0000);
      wr(CTL, 32'h0000_0010);
      rd(DAT, 32'h0000_0011);
      u_core.set_bit(`NV_B_UNLOCK, s);
      u_core.set_bit(`NV_B_START, s);
      check(32'(s), 32'(P));
      rd_cell(8'h20, 32'h0000_0011);
   endtask

   task automatic t_refused();
      wr(CTL, 32'h0000_0007);
      rd(CTL, 32'h0000_0000);
      wr(`NV_OFS_SET, 32'h0000_0006);
      u_core.set_bit(`NV_B_START, s);
      check(32'(s), 32'h0000_0000);
      u_core.set_bit(`NV_B_ABORT, s);
      rd(CTL, 32'h0000_0008);
      wr(CTL, 32'h0000_0000);
      rd(CTL, 32'h0000_0000);
   endtask

   task automatic t_abort();
      fork
         u_core.program_byte(8'h08, 8'h33, s);
         begin
            wait (stall_req === 1'b1);
            @(posedge hclk);
            hresetn <= 1'b0;
         end
      join
      check({31'h0000_0000, stall_req}, 32'h0000_0000);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(CTL, 32'h0000_0008);
      // Erase select through the set alias; a good cycle clears the flag
      wr(ADR, 32'h0000_0008);
      u_core.set_bit(`NV_B_FREE, s);
      u_core.set_bit(`NV_B_UNLOCK, s);
      u_core.set_bit(`NV_B_START, s);
      check(32'(s), 32'(P));
      rd(CTL, 32'h0000_0000);
   endtask

   task automatic tally_and_finish();
      num_errors += u_core.timeouts;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge hclk);
      t_reset_values();
      t_regs();
      t_erase_write();
      t_lapses();
      t_refused();
      t_abort();
      tally_and_finish();
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
